// *** src/ptm_top.sv ***
// Periodic timer: counter, comparators A and P, output modes, Wishbone registers
//
// Function
// - Mode field picks compare, timer, PWM, pulse
// - Clear-select low: P match or overflow clears
// - Clear-select high: A match clears, no P flag
// - Compare A zero: overflow at 3FF, no flag
// - Compare output changes only on A match or run rise
// - Run rising edge reloads initial output level
// - Timer mode counts like compare, no pin
// - PWM: P match clears, A sets duty
// - PWM period equals period value, zero 1024
// - Compare A at or above period: full duty
// - PWM raises A and P flags every match
// - PWM polarity, enable/force, invert controls apply
// - PWM counter runs while output forced
// - Pulse starts on run rise or clock edge
// - Pulse ends on run clear or A match
// - Pulse counter resets only on run rise
// - Period value split low and high byte
// - Compare B exists only in instance zero
// - Compare action codes: none, low, high, toggle
// - PWM action codes: inactive, active, PWM, pulse
//
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ptm_top
   import ptm_pkg::*;
#(
   parameter int INSTANCE = 0  // Compare B register exists only in instance 0
)
(
   input  wire logic        clk_i,        // System clock, 100 MHz
   input  wire logic        rst_i,        // Synchronous reset, active high
   input  wire logic        wb_cyc_i,     // Wishbone cycle
   input  wire logic        wb_stb_i,     // Wishbone strobe
   input  wire logic        wb_we_i,      // Wishbone write enable
   input  wire logic [5:0]  wb_adr_i,     // Byte address
   input  wire logic [3:0]  wb_sel_i,     // Byte selects
   input  wire logic [31:0] wb_dat_i,     // Write data
   output logic [31:0]      wb_dat_o,     // Read data
   output logic             wb_ack_o,     // Acknowledge
   input  wire logic        ext_clk_i,    // external_clock_pin level
   output logic             pin_o,        // Timer output pin level
   output logic             pin_oe_o      // High while the timer drives the pin
);

   // ==============================================================
   // Register state
   // ==============================================================
   logic       run;         // counter_run
   logic [2:0] clk_div;     // Timer clock select
   logic [7:0] ctrl1;       // Mode, action, level, invert, clear
   logic       flag_a;      // compare_a_flag
   logic       flag_p;      // period_flag
   logic [9:0] cmp_a;       // compare_a_value
   logic [9:0] cmp_b;       // compare_b_value
   logic [9:0] period;      // period_value
   logic       next_run;
   logic [2:0] next_clk_div;
   logic [7:0] next_ctrl1;
   logic       next_flag_a;
   logic       next_flag_p;
   logic [9:0] next_cmp_a;
   logic [9:0] next_cmp_b;
   logic [9:0] next_period;

   // ==============================================================
   // Timer state
   // ==============================================================
   logic [9:0] cnt;         // 10-bit counter
   logic       run_d;       // Run level one cycle ago
   logic       ext_d;       // External pin level one cycle ago
   logic       out_lvl;     // Compare mode output latch
   logic       ack;         // Registered acknowledge
   logic [31:0] rdata;      // Registered read data
   logic [9:0] next_cnt;
   logic       next_out_lvl;
   logic       next_ack;
   logic [31:0] next_rdata;

   // Decoded control fields
   logic       clr_sel;
   logic       inv;
   logic       init_lvl;
   logic [1:0] act;
   logic [1:0] mode;
   ptm_op_e    op;          // Effective operating mode
   logic       tick;        // Timer clock enable
   logic       run_rise;    // Run went low to high this cycle
   logic       ext_rise;    // Active edge on the external clock pin
   logic       match_a;     // Comparator A match on this tick
   logic       match_p;     // Comparator P match on this tick
   logic       wr;          // Bus write strobe
   logic       rd_hit;      // Address maps to a register

   assign clr_sel  = ctrl1[PTM_BIT_CLR];
   assign inv      = ctrl1[PTM_BIT_INV];
   assign init_lvl = ctrl1[PTM_BIT_INIT];
   assign act      = ctrl1[PTM_BIT_ACT +: 2];
   assign mode     = ctrl1[PTM_BIT_MODE +: 2];
   assign run_rise = run & ~run_d;
   assign ext_rise = ext_clk_i & ~ext_d;
   assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ~ack & wb_sel_i[0];

   // Widen a byte register into the read word; upper bits read zero
   function automatic logic [31:0] ptm_byte(input logic [7:0] b);
      ptm_byte = {24'h000000, b};
   endfunction

   // ==============================================================
   // Timer clock enable
   // ==============================================================
   ptm_tick u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .sel_i  (clk_div),
      .tick_o (tick)
   );

   // ==============================================================
   // Mode decode
   // ==============================================================
   // Pulse: PWM mode, action at pulse code
   always_comb begin
      unique case (mode)
         PTM_MODE_CMP: op = PTM_OP_CMP;
         PTM_MODE_TMR: op = PTM_OP_TMR;
         PTM_MODE_PWM: op = (act == PTM_ACT_TOG) ? PTM_OP_PULSE : PTM_OP_PWM;
         default:      op = PTM_OP_TMR; // Capture not built: count only, no pin
      endcase
   end

   // ==============================================================
   // Comparators
   // ==============================================================
   // Match on the count being left; PWM P
   // matches one early so the period is exact
   // No match in the run-rise cycle: a stale
   // count from the last run must not fire
   always_comb begin
      match_a = run & ~run_rise & tick & (cnt == cmp_a);
      match_p = run & ~run_rise & tick & (period != PTM_CNT_ZERO)
              & (((op == PTM_OP_PWM) ? cnt + 10'h001 : cnt) == period);
      // Zero compare A only rolls over
      if (op != PTM_OP_PWM && cmp_a == PTM_CNT_ZERO) begin
         match_a = 1'b0;
      end
   end

   // ==============================================================
   // Counter and output latch
   // ==============================================================
   always_comb begin
      next_cnt     = cnt;
      next_out_lvl = out_lvl;
      if (run_rise) begin
         next_cnt     = PTM_CNT_ZERO;
         next_out_lvl = init_lvl;
      end else if (run && tick) begin
         next_cnt = cnt + 10'h001;
         unique case (op)
            PTM_OP_CMP, PTM_OP_TMR: begin
               // Clear source follows clear_select; both roll over at 3FF
               if (clr_sel ? match_a : match_p) begin
                  next_cnt = PTM_CNT_ZERO;
               end
            end
            PTM_OP_PWM: begin
               // Period match clears; a zero period rolls over after 1024
               if (match_p) begin
                  next_cnt = PTM_CNT_ZERO;
               end
            end
            PTM_OP_PULSE: begin
               // Period and clear_select play no part here
               next_cnt = cnt + 10'h001;
            end
         endcase
         if (op == PTM_OP_CMP && match_a) begin
            unique case (act)
               PTM_ACT_NONE: next_out_lvl = out_lvl;
               PTM_ACT_LOW:  next_out_lvl = 1'b0;
               PTM_ACT_HIGH: next_out_lvl = 1'b1;
               PTM_ACT_TOG:  next_out_lvl = ~out_lvl;
            endcase
         end
      end
   end

   // ==============================================================
   // Output pin
   // ==============================================================
   // PWM active while count below compare A;
   // pulse active while run is high
   always_comb begin
      logic pwm_on;
      logic [10:0] per_len;
      pwm_on  = 1'b0;
      per_len = (period == PTM_CNT_ZERO) ? 11'h400 : {1'b0, period};
      pin_o    = 1'b0;
      pin_oe_o = 1'b1;
      unique case (op)
         PTM_OP_CMP: pin_o = out_lvl ^ inv;
         PTM_OP_TMR: begin
            pin_o    = 1'b0;
            pin_oe_o = 1'b0;
         end
         PTM_OP_PWM: begin
            pwm_on = ({1'b0, cmp_a} >= per_len) | (cnt < cmp_a);
            unique case (act)
               PTM_ACT_NONE: pin_o = ~init_lvl ^ inv;
               PTM_ACT_LOW:  pin_o = init_lvl ^ inv;
               default:      pin_o = (pwm_on ? init_lvl : ~init_lvl) ^ inv;
            endcase
         end
         PTM_OP_PULSE: pin_o = (run ? init_lvl : ~init_lvl) ^ inv;
      endcase
   end

   // ==============================================================
   // Registers: next values
   // ==============================================================
   // A hardware set beats a same-cycle software clear
   always_comb begin
      next_run     = run;
      next_clk_div = clk_div;
      next_ctrl1   = ctrl1;
      next_flag_a  = flag_a;
      next_flag_p  = flag_p;
      next_cmp_a   = cmp_a;
      next_cmp_b   = cmp_b;
      next_period  = period;
      if (wr) begin
         unique case (wb_adr_i)
            PTM_OFS_CTRL0: begin
               next_run     = wb_dat_i[PTM_BIT_RUN];
               next_clk_div = wb_dat_i[PTM_BIT_CLKDIV +: 3];
            end
            PTM_OFS_CTRL1:   next_ctrl1 = wb_dat_i[7:0];
            PTM_OFS_STATUS: begin
               next_flag_a = flag_a & ~wb_dat_i[PTM_BIT_FLAG_A];
               next_flag_p = flag_p & ~wb_dat_i[PTM_BIT_FLAG_P];
            end
            PTM_OFS_CMPA_LO: next_cmp_a[7:0] = wb_dat_i[7:0];
            PTM_OFS_CMPA_HI: next_cmp_a[9:8] = wb_dat_i[1:0];
            PTM_OFS_CMPB_LO: if (INSTANCE == 0) next_cmp_b[7:0] = wb_dat_i[7:0];
            PTM_OFS_CMPB_HI: if (INSTANCE == 0) next_cmp_b[9:8] = wb_dat_i[1:0];
            PTM_OFS_PER_LO:  next_period[7:0] = wb_dat_i[7:0];
            PTM_OFS_PER_HI:  next_period[9:8] = wb_dat_i[1:0];
            default: ;
         endcase
      end
      // Single pulse: an external edge sets run, a compare A match clears it
      if (op == PTM_OP_PULSE && ext_rise) begin
         next_run = 1'b1;
      end
      if (op == PTM_OP_PULSE && match_a) begin
         next_run = 1'b0;
      end
      // P flag in compare/timer only when A is not the clear source
      if (match_a) begin
         next_flag_a = 1'b1;
      end
      if (match_p && !(op != PTM_OP_PWM && clr_sel) && op != PTM_OP_PULSE) begin
         next_flag_p = 1'b1;
      end
   end

   // ==============================================================
   // Bus read and acknowledge
   // ==============================================================
   // Ack one cycle after the strobe, one cycle long
   always_comb begin
      rd_hit     = 1'b1;
      next_rdata = 32'h00000000;
      unique case (wb_adr_i)
         PTM_OFS_CTRL0:   next_rdata = ptm_byte({4'h0, clk_div, run});
         PTM_OFS_CTRL1:   next_rdata = ptm_byte(ctrl1);
         PTM_OFS_STATUS:  next_rdata = ptm_byte({6'h00, flag_p, flag_a});
         PTM_OFS_CNT_LO:  next_rdata = ptm_byte(cnt[7:0]);
         PTM_OFS_CNT_HI:  next_rdata = ptm_byte({6'h00, cnt[9:8]});
         PTM_OFS_CMPA_LO: next_rdata = ptm_byte(cmp_a[7:0]);
         PTM_OFS_CMPA_HI: next_rdata = ptm_byte({6'h00, cmp_a[9:8]});
         PTM_OFS_CMPB_LO: next_rdata = ptm_byte(cmp_b[7:0]);
         PTM_OFS_CMPB_HI: next_rdata = ptm_byte({6'h00, cmp_b[9:8]});
         PTM_OFS_PER_LO:  next_rdata = ptm_byte(period[7:0]);
         PTM_OFS_PER_HI:  next_rdata = ptm_byte({6'h00, period[9:8]});
         default:         rd_hit = 1'b0; // Unmapped reads zero, still acked
      endcase
      next_ack = wb_cyc_i & wb_stb_i & ~ack;
   end

   // ==============================================================
   // State registers
   // ==============================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run      <= 1'b0;
         clk_div  <= PTM_DIV_DFLT;
         ctrl1    <= PTM_RST_BYTE;
         flag_a   <= 1'b0;
         flag_p   <= 1'b0;
         cmp_a    <= PTM_CNT_ZERO;
         cmp_b    <= PTM_CNT_ZERO;
         period   <= PTM_CNT_ZERO;
         cnt      <= PTM_CNT_ZERO;
         run_d    <= 1'b0;
         ext_d    <= 1'b0;
         out_lvl  <= 1'b0;
         ack      <= 1'b0;
         rdata    <= 32'h00000000;
      end else begin
         run      <= next_run;
         clk_div  <= next_clk_div;
         ctrl1    <= next_ctrl1;
         flag_a   <= next_flag_a;
         flag_p   <= next_flag_p;
         cmp_a    <= next_cmp_a;
         cmp_b    <= next_cmp_b;
         period   <= next_period;
         cnt      <= next_cnt;
         run_d    <= run;
         ext_d    <= ext_clk_i;
         out_lvl  <= next_out_lvl;
         ack      <= next_ack;
         rdata    <= rd_hit ? next_rdata : 32'h00000000;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

endmodule

// *** src/ptm_pkg.sv ***
// Package: register map, field positions, reset values and modes of the periodic timer
package ptm_pkg;

   // ==============================================================
   // Register word offsets (byte addresses, one aligned word each)
   // ==============================================================
   localparam logic [5:0] PTM_OFS_CTRL0   = 6'h00; // Run and clock select
   localparam logic [5:0] PTM_OFS_CTRL1   = 6'h04; // Mode, action, level, invert, clear
   localparam logic [5:0] PTM_OFS_STATUS  = 6'h08; // Flags, write one to clear
   localparam logic [5:0] PTM_OFS_CNT_LO  = 6'h0c; // Counter bits 7..0, read only
   localparam logic [5:0] PTM_OFS_CNT_HI  = 6'h10; // Counter bits 9..8, read only
   localparam logic [5:0] PTM_OFS_CMPA_LO = 6'h14; // compare_a_value low byte
   localparam logic [5:0] PTM_OFS_CMPA_HI = 6'h18; // compare_a_value high byte
   localparam logic [5:0] PTM_OFS_CMPB_LO = 6'h1c; // compare_b_value low byte
   localparam logic [5:0] PTM_OFS_CMPB_HI = 6'h20; // compare_b_high_byte
   localparam logic [5:0] PTM_OFS_PER_LO  = 6'h24; // period_low_byte
   localparam logic [5:0] PTM_OFS_PER_HI  = 6'h28; // period_high_byte

   // ==============================================================
   // Field positions
   // ==============================================================
   localparam int PTM_BIT_RUN      = 0; // CTRL0: counter_run
   localparam int PTM_BIT_CLKDIV   = 1; // CTRL0: prescaler select, bits 3..1
   localparam int PTM_BIT_CLR      = 0; // CTRL1: clear_select
   localparam int PTM_BIT_INV      = 2; // CTRL1: output_invert
   localparam int PTM_BIT_INIT     = 3; // CTRL1: output_initial_level
   localparam int PTM_BIT_ACT      = 4; // CTRL1: output_action, bits 5..4
   localparam int PTM_BIT_MODE     = 6; // CTRL1: mode_select, bits 7..6
   localparam int PTM_BIT_FLAG_A   = 0; // STATUS: compare_a_flag
   localparam int PTM_BIT_FLAG_P   = 1; // STATUS: period_flag

   // ==============================================================
   // Reset values and constants
   // ==============================================================
   localparam logic [7:0] PTM_RST_BYTE  = 8'h00; // Every register after reset
   localparam logic [9:0] PTM_CNT_MAX   = 10'h3ff; // Counter wraps after this
   localparam logic [9:0] PTM_CNT_ZERO  = 10'h000;
   localparam logic [2:0] PTM_DIV_DFLT  = 3'h0;  // Timer clock = clk_i

   // ==============================================================
   // Modes and output actions
   // ==============================================================
   localparam logic [1:0] PTM_MODE_CMP  = 2'h0; // Compare match output
   localparam logic [1:0] PTM_MODE_CAP  = 2'h1; // Capture, not built here
   localparam logic [1:0] PTM_MODE_PWM  = 2'h2; // PWM or single pulse
   localparam logic [1:0] PTM_MODE_TMR  = 2'h3; // Timer/counter
   localparam logic [1:0] PTM_ACT_NONE  = 2'h0; // Compare: no change / PWM: inactive
   localparam logic [1:0] PTM_ACT_LOW   = 2'h1; // Compare: low / PWM: active
   localparam logic [1:0] PTM_ACT_HIGH  = 2'h2; // Compare: high / PWM: waveform
   localparam logic [1:0] PTM_ACT_TOG   = 2'h3; // Compare: toggle / single pulse

   typedef enum logic [1:0] {
      PTM_OP_CMP,
      PTM_OP_TMR,
      PTM_OP_PWM,
      PTM_OP_PULSE
   } ptm_op_e;

endpackage

// *** src/ptm_tick.sv ***
// Timer clock enable divider: one-cycle tick at clk_i / 2^sel
`timescale 1ns/1ps
module ptm_tick
   import ptm_pkg::*;
(
   input  wire logic       clk_i,   // System clock
   input  wire logic       rst_i,   // Synchronous reset
   input  wire logic [2:0] sel_i,   // Divide by 2^sel
   output logic            tick_o   // One-cycle timer clock enable
);

   logic [6:0] div;       // Free running prescaler
   logic [6:0] next_div;  // Next prescaler value

   // ==============================================================
   // Prescaler
   // ==============================================================
   // Next prescaler count
   always_comb begin
      next_div = div + 7'h01;
   end

   // Register the prescaler
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= 7'h00;
      end else begin
         div <= next_div;
      end
   end

   // Tick when the low sel bits are all ones
   always_comb begin
      tick_o = ((div & ((7'h01 << sel_i) - 7'h01)) == ((7'h01 << sel_i) - 7'h01));
   end

endmodule

// *** tb/ptm_pin_partner.sv ***
// Far side: pulled-down output pin and clock pin
`timescale 1ns/1ps
module ptm_pin_partner (
   input  wire logic clk_i,     // System clock
   input  wire logic pin_o,     // Level the timer offers
   input  wire logic pin_oe_o,  // Timer drives the pin
   input  wire logic trig_i,    // Bench asks for one edge on the clock pin
   output logic      ext_clk_o, // external_clock_pin level
   output logic      pin_lvl_o  // Level seen on the board
);
   logic [1:0] hold = 2'h0;     // Cycles the clock pin stays high
   // =========================================
   // Pin wire: released pin falls to the pull-down
   assign pin_lvl_o = pin_oe_o ? pin_o : 1'b0;
   // =========================================
   // Clock pin: one rise, held three cycles
   always_ff @(posedge clk_i) begin
      if (trig_i) begin
         hold <= 2'h3;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end
   end
   assign ext_clk_o = (hold != 2'h0);
endmodule

// *** tb/ptm_top_assertions.sv ***
// Checker of the periodic timer ports
`timescale 1ns/1ps
module ptm_top_assertions
   import ptm_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        ext_clk_i,
   input wire logic        pin_o,
   input wire logic        pin_oe_o
);
   // =========================================
   // Control shadow from the bus
   logic [7:0] ctl1, next_ctl1; // Mode, action, level, invert
   logic       run, next_run;   // Software view of counter_run
   logic [1:0] perh, next_perh; // Period bits 9..8
   logic       wr;              // Write taken at this edge
   logic       lvl;             // Active level after invert
   assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   assign lvl = ctl1[PTM_BIT_INIT] ^ ctl1[PTM_BIT_INV];
   // Next shadow values; run auto-clear unseen
   always_comb begin
      next_ctl1 = (wr && wb_adr_i == PTM_OFS_CTRL1) ? wb_dat_i[7:0] : ctl1;
      next_run  = (wr && wb_adr_i == PTM_OFS_CTRL0) ? wb_dat_i[0] : run;
      next_perh = (wr && wb_adr_i == PTM_OFS_PER_HI) ? wb_dat_i[1:0] : perh;
   end
   // Register the shadow
   always_ff @(posedge clk_i) begin
      ctl1 <= rst_i ? 8'h00 : next_ctl1;
      run  <= rst_i ? 1'b0 : next_run;
      perh <= rst_i ? 2'h0 : next_perh;
   end
   // =========================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   AST_ACK_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   AST_UPPER_ZERO:
      assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
   AST_PER_HI_READ:
      assert property (wb_ack_o && !wb_we_i && wb_adr_i == PTM_OFS_PER_HI
         |-> wb_dat_o[7:0] == {6'h0, perh}) else $error("period high byte");
   AST_CMPB_HI_ZERO:
      assert property (wb_ack_o && !wb_we_i && wb_adr_i == PTM_OFS_CMPB_HI
         |-> wb_dat_o[7:2] == 6'h0) else $error("compare b high bits");
   AST_TMR_NO_PIN:
      assert property (ctl1[7:6] == PTM_MODE_TMR |-> !pin_oe_o) else $error("timer drives pin");
   AST_OE_DRIVE:
      assert property (ctl1[7:6] == PTM_MODE_CMP || ctl1[7:6] == PTM_MODE_PWM |-> pin_oe_o)
         else $error("pin released");
   AST_FORCE_OFF:
      assert property ((ctl1[7:4] == {PTM_MODE_PWM, PTM_ACT_NONE}) [*2] |-> pin_o == !lvl)
         else $error("forced inactive");
   AST_FORCE_ON:
      assert property ((ctl1[7:4] == {PTM_MODE_PWM, PTM_ACT_LOW}) [*2] |-> pin_o == lvl)
         else $error("forced active");
   AST_RUN_RELOAD:
      assert property (wr && wb_adr_i == PTM_OFS_CTRL0 && wb_dat_i[0] && !run
         && ctl1[7:6] == PTM_MODE_CMP |-> ##2 pin_o == lvl) else $error("initial level");
   // Main scenarios reached
   COV_RUN: cover property (wr && wb_adr_i == PTM_OFS_CTRL0 && wb_dat_i[0]);
   COV_PWM: cover property (ctl1[7:4] == {PTM_MODE_PWM, PTM_ACT_HIGH} && pin_o);
   COV_EXT: cover property ($rose(ext_clk_i) && ctl1[7:4] == {PTM_MODE_PWM, PTM_ACT_TOG});
endmodule
bind ptm_top ptm_top_assertions i_ptm_top_assertions (.*);

// *** tb/ptm_top_tb.sv ***
// Testbench of the periodic timer
`timescale 1ns/1ps
module ptm_top_tb
   import ptm_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [5:0]  wb_adr_i = 6'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rnd = 32'hfe74;
   logic        wb_ack_o, pin_o, pin_oe_o, ext_clk, pin_lvl, trig = 1'b0;
   logic [7:0]  q;             // Last read byte
   logic [9:0]  a, p;          // Compare A and period under test
   int          mismatches = 0, num_checks = 0, n, w;
   logic [5:0]  ofs [10] = '{PTM_OFS_CTRL0, PTM_OFS_CTRL1, PTM_OFS_STATUS, PTM_OFS_CNT_LO,
      PTM_OFS_CMPA_LO, PTM_OFS_CMPA_HI, PTM_OFS_CMPB_LO, PTM_OFS_CMPB_HI, PTM_OFS_PER_HI, 6'h3c};
   always #5 clk_i = ~clk_i;
   ptm_top i_ptm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o));
   ptm_pin_partner i_ptm_pin_partner (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
      .trig_i(trig), .ext_clk_o(ext_clk), .pin_lvl_o(pin_lvl));
   // =========================================
   // Expectation helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic exp_pin(input logic [1:0] act, input logic init);
      return (act == PTM_ACT_NONE) ? init : (act == PTM_ACT_TOG) ? ~init : act[1];
   endfunction
   // Active cycles in one period
   function automatic int exp_duty(input logic [9:0] da, input logic [9:0] dp);
      return (dp != 10'h0 && da >= dp) ? int'(dp) : int'(da);
   endfunction
   // =========================================
   // Bus, compare and closing tasks
   task automatic bus(input logic we, input logic [5:0] ad, input logic [7:0] d);
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= ad;
      wb_sel_i <= 4'hf; wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [5:0] ad, input logic [7:0] d); bus(1'b1, ad, d); endtask
   task automatic set10(input logic [5:0] lo, input logic [9:0] v);
      wr(lo, v[7:0]);
      wr(lo + 6'h04, {6'h0, v[9:8]});
   endtask
   task automatic cfg(input logic [1:0] m, ac, input logic i, v, c);
      wr(PTM_OFS_CTRL0, 8'h00);  // Stop: unsafe to change running
      wr(PTM_OFS_STATUS, 8'h03);
      wr(PTM_OFS_CTRL1, {m, ac, i, v, 1'b0, c});
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog: the run needs under 8000 cycles
   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      finish_test;
   end
   // =========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (ofs[i]) begin bus(1'b0, ofs[i], 8'h00); chk("reset", q, 8'h00); end
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wr(PTM_OFS_PER_HI, rnd[7:0]); bus(1'b0, PTM_OFS_PER_HI, 8'h0);
         chk("per_hi", q, {6'h0, rnd[1:0]});
         wr(PTM_OFS_CMPB_HI, rnd[15:8]); bus(1'b0, PTM_OFS_CMPB_HI, 8'h0);
         chk("cmpb_hi", q, {6'h0, rnd[9:8]});
         wr(6'h3c, rnd[23:16]); bus(1'b0, 6'h3c, 8'h0);
         chk("unmapped", q, 8'h00);
      end
      // Compare/timer: P clear, A clear, overflow
      for (int k = 0; k < 4; k++) begin
         cfg(k == 3 ? PTM_MODE_TMR : PTM_MODE_CMP, PTM_ACT_NONE, 1'b0, 1'b0, k == 1);
         set10(PTM_OFS_CMPA_LO, k == 2 ? 10'h0 : (k == 1 ? 10'd10 : 10'd6));
         set10(PTM_OFS_PER_LO, k == 2 ? 10'h0 : (k == 1 ? 10'd3 : 10'd20));
         wr(PTM_OFS_CTRL0, 8'h01);
         repeat (k == 2 ? 1100 : 60) @(posedge clk_i);
         bus(1'b0, PTM_OFS_CNT_LO, 8'h0);
         if (k == 1) chk("cnt_a", q <= 8'd10, 1'b1);
         bus(1'b0, PTM_OFS_STATUS, 8'h0);
         chk("flags", q, k == 2 ? 8'h00 : (k == 1 ? 8'h01 : 8'h03));
         if (k == 3) chk("oe", pin_oe_o, 1'b0);
      end
      // Each compare action: one A match at count 8
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         cfg(PTM_MODE_CMP, k[1:0], rnd[0], 1'b0, 1'b0);
         set10(PTM_OFS_CMPA_LO, 10'd8);
         set10(PTM_OFS_PER_LO, 10'd0);
         wr(PTM_OFS_CTRL0, 8'h01);
         repeat (30) @(posedge clk_i);
         chk("cmp_pin", pin_lvl, exp_pin(k[1:0], rnd[0]));
      end
      // PWM duty, full duty, 1024 period, forced levels
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         p = (k == 3) ? 10'h0 : {4'h0, rnd[5:0]} + 10'd4;
         a = (k == 3) ? 10'd300 : (k == 2) ? p : rnd[17:8] % p;
         w = (p == 10'h0) ? 1024 : int'(p);
         cfg(PTM_MODE_PWM, PTM_ACT_HIGH, 1'b1, k[0], ~k[0]);
         set10(PTM_OFS_CMPA_LO, a);
         set10(PTM_OFS_PER_LO, p);
         wr(PTM_OFS_CTRL0, 8'h01);
         repeat (8) @(posedge clk_i);
         n = 0;
         for (int i = 0; i < w; i++) begin @(posedge clk_i); n += (pin_lvl === ~k[0]); end
         chk("duty", n, exp_duty(a, p));
         bus(1'b0, PTM_OFS_STATUS, 8'h0);
         if (k < 2) chk("pwm_flags", q, 8'h03);
         cfg(PTM_MODE_PWM, k[0] ? PTM_ACT_LOW : PTM_ACT_NONE, 1'b1, k[0], 1'b0);
         wr(PTM_OFS_CTRL0, 8'h01);
         repeat (w + 10) @(posedge clk_i);
         bus(1'b0, PTM_OFS_STATUS, 8'h0);
         chk("forced_p", q[1], p != 10'h0);
      end
      // Single pulse: clock pin, then software
      for (int k = 0; k < 2; k++) begin
         cfg(PTM_MODE_PWM, PTM_ACT_TOG, 1'b1, 1'b0, 1'b0);
         set10(PTM_OFS_CMPA_LO, 10'd12);
         set10(PTM_OFS_PER_LO, 10'd3);
         if (k == 0) begin trig <= 1'b1; @(posedge clk_i); trig <= 1'b0; end
         else wr(PTM_OFS_CTRL0, 8'h01);
         repeat (4) @(posedge clk_i);
         chk("pulse_on", pin_lvl, 1'b1);
         repeat (40) @(posedge clk_i);
         chk("pulse_off", pin_lvl, 1'b0);
         bus(1'b0, PTM_OFS_CTRL0, 8'h0);
         chk("run_auto", q[0], 1'b0);
         bus(1'b0, PTM_OFS_STATUS, 8'h0);
         chk("pulse_flags", q, 8'h01);
      end
      finish_test;
   end
endmodule
